/* core/bioe_pkg.sv */
package bioe_pkg;

    // Instruction word layout.
    localparam int          BIOE_IW_W       = 14;
    localparam int          BIOE_PC_W       = 13;
    localparam int          BIOE_LIT_W      = 11;
    localparam int          BIOE_FADDR_W    = 7;
    localparam int          BIOE_DEST_BIT   = 7;
    localparam int          BIOE_LATCH_LO   = 3;
    localparam int          BIOE_LATCH_HI   = 4;
    localparam int          BIOE_STATUS_Z   = 2;

    // Opcode matching: word & mask == pattern.
    localparam logic [13:0] BIOE_JMP_MASK   = 14'h3800;
    localparam logic [13:0] BIOE_JMP_PAT    = 14'h2800;
    localparam logic [13:0] BIOE_BYTE_MASK  = 14'h3f00;
    localparam logic [13:0] BIOE_INCSZ_PAT  = 14'h0f00;
    localparam logic [13:0] BIOE_INC_PAT    = 14'h0a00;
    localparam logic [13:0] BIOE_ORL_PAT    = 14'h3800;

    // Reset values.
    localparam logic [12:0] BIOE_PC_RST     = 13'h0000;
    localparam logic [7:0]  BIOE_ACC_RST    = 8'h00;
    localparam logic [7:0]  BIOE_STATUS_RST = 8'h00;

    typedef enum logic [1:0] {
        BIOE_OP_NONE,
        BIOE_OP_JUMP,
        BIOE_OP_INC,
        BIOE_OP_ORL
    } bioe_op_t;

    // Decoded fields of one instruction word.
    typedef struct packed {
        bioe_op_t    op;
        logic        skip_on_zero;
        logic        dest_file;
        logic [6:0]  faddr;
        logic [10:0] literal;
    } bioe_dec_t;

    // File register write request.
    typedef struct packed {
        logic       we;
        logic [6:0] addr;
        logic [7:0] data;
    } bioe_fwr_t;

endpackage

/* core/bioe_decode.sv */
`timescale 1ns/1ps
module bioe_decode
    import bioe_pkg::*;
(
    // Instruction in
    input  wire logic [13:0] instr,
    // Decoded fields out
    output bioe_dec_t        dec
);

    always_comb
    begin
        dec              = '0;
        dec.op           = BIOE_OP_NONE;
        dec.faddr        = instr[BIOE_FADDR_W-1:0];
        dec.dest_file    = instr[BIOE_DEST_BIT];
        dec.literal      = instr[BIOE_LIT_W-1:0];
        if ((instr & BIOE_JMP_MASK) == BIOE_JMP_PAT)
        begin
            dec.op = BIOE_OP_JUMP;
        end
        else if ((instr & BIOE_BYTE_MASK) == BIOE_INCSZ_PAT)
        begin
            dec.op           = BIOE_OP_INC;
            dec.skip_on_zero = 1'b1;
        end
        else if ((instr & BIOE_BYTE_MASK) == BIOE_INC_PAT)
        begin
            dec.op = BIOE_OP_INC;
        end
        else if ((instr & BIOE_BYTE_MASK) == BIOE_ORL_PAT)
        begin
            dec.op = BIOE_OP_ORL;
        end
    end

endmodule

/* core/bioe_core.sv */
`timescale 1ns/1ps
// Functional notes
// - Jump copies 11-bit literal into PC low.
// - Jump fills PC top from latch bits 4:3.
// - Jump takes two cycles, flags untouched.
// - Skip-increment zero result flushes prefetch, two cycles.
// - Destination bit picks accumulator or file register.
// - Plain increment updates zero, one cycle, no skip.
// - OR literal into accumulator in one cycle.
// - OR result to accumulator, only zero flag changes.
module bioe_core
    import bioe_pkg::*;
(
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        resetn,
    // Instruction stream, one word per instruction cycle
    input  wire logic        instr_valid,
    input  wire logic [13:0] instr,
    input  wire logic [7:0]  pc_high_latch,
    // File register read data for the addressed register
    input  wire logic [7:0]  file_rdata,
    // Architectural state
    output logic      [12:0] pc_r,
    output logic      [7:0]  acc_r,
    output logic      [7:0]  status_r,
    // File register write port
    output bioe_fwr_t        fwr_r,
    // High during the second, discarded cycle of a two-cycle instruction
    output logic             flush_r
);

    bioe_dec_t  dec;
    logic       exec;
    logic [7:0] inc_val;
    logic [7:0] orl_val;

    bioe_decode u_decode
    (
        .instr (instr),
        .dec   (dec)
    );

    // The word arriving during a flush cycle is the stale prefetch and is never executed.
    assign exec    = instr_valid && !flush_r;
    assign inc_val = file_rdata + 8'h01;
    assign orl_val = acc_r | dec.literal[7:0];

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            pc_r <= BIOE_PC_RST;
        end
        else if (exec && dec.op == BIOE_OP_JUMP)
        begin
            pc_r <= {pc_high_latch[BIOE_LATCH_HI:BIOE_LATCH_LO], dec.literal};
        end
        else if (instr_valid)
        begin
            pc_r <= pc_r + 13'h0001;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            flush_r <= 1'b0;
        end
        else if (exec && dec.op == BIOE_OP_JUMP)
        begin
            flush_r <= 1'b1;
        end
        else if (exec && dec.op == BIOE_OP_INC && dec.skip_on_zero && inc_val == 8'h00)
        begin
            flush_r <= 1'b1;
        end
        else if (instr_valid)
        begin
            flush_r <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            acc_r <= BIOE_ACC_RST;
        end
        else if (exec && dec.op == BIOE_OP_INC && !dec.dest_file)
        begin
            acc_r <= inc_val;
        end
        else if (exec && dec.op == BIOE_OP_ORL)
        begin
            acc_r <= orl_val;
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            fwr_r <= '0;
        end
        else
        begin
            fwr_r.we   <= exec && dec.op == BIOE_OP_INC && dec.dest_file;
            fwr_r.addr <= dec.faddr;
            fwr_r.data <= inc_val;
        end
    end

    // Only plain increment and OR literal touch the zero flag; the skip form leaves status alone.
    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            status_r <= BIOE_STATUS_RST;
        end
        else if (exec && dec.op == BIOE_OP_INC && !dec.skip_on_zero)
        begin
            status_r[BIOE_STATUS_Z] <= (inc_val == 8'h00);
        end
        else if (exec && dec.op == BIOE_OP_ORL)
        begin
            status_r[BIOE_STATUS_Z] <= (orl_val == 8'h00);
        end
    end

    jump_pc_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        exec && dec.op == BIOE_OP_JUMP |=> pc_r == {$past(pc_high_latch[4:3]), $past(instr[10:0])})
        else $error("jump target wrong");
    jump_top_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        exec && dec.op == BIOE_OP_JUMP |=> pc_r[12:11] == $past(pc_high_latch[4:3]))
        else $error("jump upper bits wrong");
    jump_flush_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        exec && dec.op == BIOE_OP_JUMP |=> flush_r && $stable(status_r) && $stable(acc_r))
        else $error("jump not two cycles or flags moved");
    skip_flush_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        exec && dec.op == BIOE_OP_INC && dec.skip_on_zero |=> flush_r == ($past(file_rdata) == 8'hff))
        else $error("skip decision wrong");
    inc_dest_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        exec && dec.op == BIOE_OP_INC |=> (fwr_r.we == $past(instr[7]))
        && (fwr_r.we || acc_r == $past(file_rdata) + 8'h01))
        else $error("increment destination wrong");
    inc_once_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        exec && dec.op == BIOE_OP_INC && !dec.skip_on_zero |=> !flush_r
        && status_r[2] == ($past(file_rdata) == 8'hff))
        else $error("plain increment wrong");
    orl_value_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        exec && dec.op == BIOE_OP_ORL |=> acc_r == ($past(acc_r) | $past(instr[7:0])) && !flush_r)
        else $error("or literal result wrong");
    orl_flags_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        exec && dec.op == BIOE_OP_ORL |=> status_r[2] == (acc_r == 8'h00)
        && {status_r[7:3], status_r[1:0]} == $past({status_r[7:3], status_r[1:0]}))
        else $error("or literal flags wrong");
    zero_wrap_a: assert property (@(posedge ref_clk) disable iff (!resetn)
        exec && dec.op == BIOE_OP_INC && !dec.dest_file && file_rdata == 8'hff |=> acc_r == 8'h00)
        else $error("increment did not wrap");

endmodule

/* bench/testbench.sv */
`timescale 1ns/1ps
module testbench
    import bioe_pkg::*;
;
    logic        ref_clk;
    logic        resetn;
    logic        instr_valid;
    logic [13:0] instr;
    logic [7:0]  pc_high_latch;
    logic [7:0]  file_rdata;
    logic [12:0] pc_r;
    logic [7:0]  acc_r;
    logic [7:0]  status_r;
    bioe_fwr_t   fwr_r;
    logic        flush_r;
    int          error_cnt;
    int          compares;
    logic [31:0] seed;
    logic [13:0] w;
    logic [12:0] m_pc;
    logic [7:0]  m_acc;
    logic        m_z;
    logic        m_fl;
    logic        m_we;
    logic [6:0]  m_wa;
    logic [7:0]  m_wd;
    logic        p_v;
    logic [13:0] p_w;
    logic [7:0]  p_lat;
    logic [7:0]  p_fd;

    bioe_core dut (
        .ref_clk       (ref_clk),
        .resetn        (resetn),
        .instr_valid   (instr_valid),
        .instr         (instr),
        .pc_high_latch (pc_high_latch),
        .file_rdata    (file_rdata),
        .pc_r          (pc_r),
        .acc_r         (acc_r),
        .status_r      (status_r),
        .fwr_r         (fwr_r),
        .flush_r       (flush_r)
    );

    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction

    task automatic chk(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Works on the word the core sampled at this edge, not the one just driven.
    function automatic void predict();
        logic [7:0] res;
        res = p_fd + 8'h01;
        m_we = 1'b0;
        m_wa = p_w[6:0];
        m_wd = res;
        if (!p_v)
            return;
        m_pc = m_pc + 13'h0001;
        if (m_fl)
            m_fl = 1'b0;
        else if ((p_w & BIOE_JMP_MASK) == BIOE_JMP_PAT)
        begin
            m_pc = {p_lat[4:3], p_w[10:0]};
            m_fl = 1'b1;
        end
        else if ((p_w & BIOE_BYTE_MASK) == BIOE_ORL_PAT)
        begin
            m_acc = m_acc | p_w[7:0];
            m_z = (m_acc == 8'h00);
        end
        else if ((p_w & BIOE_BYTE_MASK) == BIOE_INC_PAT || (p_w & BIOE_BYTE_MASK) == BIOE_INCSZ_PAT)
        begin
            if (p_w[7])
                m_we = 1'b1;
            else
                m_acc = res;
            if (p_w[8])
                m_fl = (res == 8'h00);
            else
                m_z = (res == 8'h00);
        end
    endfunction

    task automatic step(input logic v, input logic [13:0] iw, input logic [7:0] lat, input logic [7:0] fd);
        @(posedge ref_clk);
        instr_valid <= v;
        instr <= iw;
        pc_high_latch <= lat;
        file_rdata <= fd;
        predict();
        {p_v, p_w, p_lat, p_fd} = {v, iw, lat, fd};
        #1;
        chk("pc", {3'h0, pc_r}, {3'h0, m_pc});
        chk("acc", {8'h00, acc_r}, {8'h00, m_acc});
        chk("status", {8'h00, status_r}, {13'h0000, m_z, 2'h0});
        chk("flush", {15'h0000, flush_r}, {15'h0000, m_fl});
        chk("fwr_we", {15'h0000, fwr_r.we}, {15'h0000, m_we});
        if (m_we)
            chk("fwr", fwr_r, {1'b1, m_wa, m_wd});
    endtask

    task tally_and_finish();
        if (error_cnt == 0 && compares > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    initial
    begin
        #200000;
        error_cnt++;
        tally_and_finish();
    end

    initial
    begin
        {resetn, instr_valid, instr, pc_high_latch, file_rdata} = '0;
        {error_cnt, compares, p_v, p_w, p_lat, p_fd} = '0;
        {m_pc, m_acc, m_z, m_fl} = '0;
        seed = 32'hc666cb6e;
        repeat (5) @(posedge ref_clk);
        resetn <= 1'b1;
        #1;
        chk("rst_pc", {3'h0, pc_r}, 16'h0000);
        chk("rst_acc_status", {acc_r, status_r}, 16'h0000);
        chk("rst_fwr", fwr_r, 16'h0000);
        step(1'b1, 14'h3800, 8'h00, 8'h00);
        step(1'b1, 14'h3835, 8'h00, 8'h00);
        step(1'b1, 14'h0f85, 8'h00, 8'hff);
        step(1'b1, 14'h3800, 8'h00, 8'h00);
        step(1'b1, 14'h0a7f, 8'h00, 8'hff);
        step(1'b1, 14'h2fff, 8'h18, 8'h00);
        step(1'b0, 14'h3801, 8'h00, 8'h00);
        step(1'b1, 14'h0f00, 8'h00, 8'h01);
        // Rdata of all-ones on half of the words keeps the wrap case frequent.
        repeat (2000)
        begin
            seed = xs(seed);
            case (seed[2:0])
                3'h0, 3'h1: w = {3'b101, seed[20:10]};
                3'h2:       w = {6'h0f, seed[15:8]};
                3'h3:       w = {6'h0a, seed[15:8]};
                3'h4:       w = {6'h38, seed[15:8]};
                default:    w = seed[29:16];
            endcase
            step(seed[31:28] != 4'h0, w, seed[27:20], seed[5] ? 8'hff : seed[13:6]);
        end
        tally_and_finish();
    end
endmodule
